// *** rtl/io_gearbox_serdes.sv ***
// Input and output gearboxes with two-entry buffers on the core side
`timescale 1ns/1ps
`default_nettype none

module gearbox_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_r [2];
    logic             wr_ptr_r;
    logic             rd_ptr_r;
    logic [1:0]       count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != 2'h2);
    assign out_valid_o = (count_r != 2'h0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop)
            begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // gearbox_buf2

// Functional notes
// - Input path is three register stages.
// - Input samples pin on both edges in eight and four modes, rising edge only in seven mode.
// - Alignment steered by load strobe and select.
// - Aligned word presented on slow tick.
// - Output gearbox serializes up to eight bits.
// - Seven, eight, or dual four ratio modes.
// - Output: slow capture, transfer, fast shift.
// - Slow tick, dual-edge pair output, reset.
module io_gearbox_serdes
    import gearbox_pkg::*;
#(
    parameter int unsigned DATA_W = WORD_W
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // Configuration
    input  wire logic [1:0]        ratio_mode_i,
    input  wire logic              align_load_i,
    input  wire logic              align_select_i,
    // Pin input samples, rising and falling edge
    input  wire logic              pin_rise_i,
    input  wire logic              pin_fall_i,
    // Pin outputs: index 0 first_io_cell, 1 second_io_cell
    output logic      [1:0]        q_rise_o,
    output logic      [1:0]        q_fall_o,
    // Slow system clock enable
    output logic                   sys_tick_o,
    // Core transmit stream
    input  wire logic              tx_valid_i,
    output logic                   tx_ready_o,
    input  wire logic [DATA_W-1:0] tx_data_i,
    // Core receive stream
    output logic                   rx_valid_o,
    input  wire logic              rx_ready_i,
    output logic      [DATA_W-1:0] rx_data_o,
    output logic                   rx_drop_o
);
    if (DATA_W != WORD_W)
    begin : g_width_check
        $error("DATA_W must equal the gearbox word width");
    end

    function automatic logic [PHASE_W-1:0] ticks_of(input logic [1:0] m);
        case (m)
            DUAL_EDGE_EIGHT_TO_ONE_MODE: ticks_of = PHASE_W'(TICKS_EIGHT);
            DUAL_EDGE_FOUR_TO_ONE_MODE:  ticks_of = PHASE_W'(TICKS_FOUR);
            default:                     ticks_of = PHASE_W'(TICKS_SEVEN);
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] extract(input logic [HIST_W-1:0] h,
                                                  input logic [1:0] m,
                                                  input logic off);
        logic [HIST_W-1:0] s;
        logic [4:0]        n;
        s = '0;
        case (m)
            DUAL_EDGE_EIGHT_TO_ONE_MODE: n = 5'(BITS_EIGHT);
            DUAL_EDGE_FOUR_TO_ONE_MODE:  n = 5'(BITS_FOUR);
            default:                     n = 5'(BITS_SEVEN);
        endcase
        s = h >> (5'(HIST_W) - n - {4'h0, off});
        s = s & ((HIST_W'(1) << n) - HIST_W'(1));
        extract = s[DATA_W-1:0];
    endfunction

    logic                  rise_s1_r, rise_s2_r, fall_s1_r, fall_s2_r;
    logic [PHASE_W-1:0]    phase_r;
    logic                  tick;
    logic                  align_sel_r;
    logic [HIST_W-1:0]     hist_r;
    logic [DATA_W-1:0]     aligned_r;
    logic                  aligned_vld_r;
    logic [DATA_W-1:0]     rx_word_r;
    logic                  rx_word_vld_r;
    logic                  rx_in_ready;
    logic                  txb_valid;
    logic [DATA_W-1:0]     txb_data;
    logic [DATA_W-1:0]     cap_r;
    logic [DATA_W-1:0]     sh_r;
    logic [1:0]            q_rise_r, q_fall_r;
    logic                  drop_r;

    // Slow system clock enable divider
    assign tick       = (phase_r == '0);
    assign sys_tick_o = tick;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            phase_r <= '0;
        else if (tick)
            phase_r <= ticks_of(ratio_mode_i) - PHASE_W'(1);
        else
            phase_r <= phase_r - PHASE_W'(1);
    end

    // Pin synchronisers
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            rise_s1_r <= 1'b0;
            rise_s2_r <= 1'b0;
            fall_s1_r <= 1'b0;
            fall_s2_r <= 1'b0;
        end
        else
        begin
            rise_s1_r <= pin_rise_i;
            rise_s2_r <= rise_s1_r;
            fall_s1_r <= pin_fall_i;
            fall_s2_r <= fall_s1_r;
        end
    end

    // Input stage one: capture history, dual-edge except rising edge only in seven mode
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            hist_r <= '0;
        else if (ratio_mode_i == SEVEN_TO_ONE_MODE)
            hist_r <= {rise_s2_r, hist_r[HIST_W-1:1]};
        else
            hist_r <= {fall_s2_r, rise_s2_r, hist_r[HIST_W-1:2]};
    end

    // Input stage two: alignment
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            align_sel_r   <= 1'b0;
            aligned_r     <= WORD_RESET;
            aligned_vld_r <= 1'b0;
        end
        else
        begin
            if (align_load_i)
                align_sel_r <= align_select_i;
            aligned_vld_r <= tick;
            if (tick)
                aligned_r <= extract(hist_r, ratio_mode_i, align_sel_r);
        end
    end

    // Input stage three: word to core on slow tick
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            rx_word_r     <= WORD_RESET;
            rx_word_vld_r <= 1'b0;
            drop_r        <= 1'b0;
        end
        else
        begin
            rx_word_vld_r <= aligned_vld_r;
            if (aligned_vld_r)
                rx_word_r <= aligned_r;
            drop_r <= rx_word_vld_r && !rx_in_ready;
        end
    end
    assign rx_drop_o = drop_r;

    gearbox_buf2 #(.WIDTH(DATA_W)) rx_buf (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (rx_word_vld_r),
        .in_ready_o  (rx_in_ready),
        .in_data_i   (rx_word_r),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    gearbox_buf2 #(.WIDTH(DATA_W)) tx_buf (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .in_data_i   (tx_data_i),
        .out_valid_o (txb_valid),
        .out_ready_i (tick),
        .out_data_o  (txb_data)
    );

    // Output stages one and two: slow capture, transfer to shifter
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            cap_r <= WORD_RESET;
        else if (tick)
            cap_r <= txb_valid ? txb_data : WORD_RESET;
    end

    // Output stage three: shift and multiplex onto the pin pair
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            sh_r     <= WORD_RESET;
            q_rise_r <= 2'h0;
            q_fall_r <= 2'h0;
        end
        else
        begin
            case (ratio_mode_i)
                DUAL_EDGE_EIGHT_TO_ONE_MODE:
                begin
                    q_rise_r <= {1'b0, sh_r[0]};
                    q_fall_r <= {1'b0, sh_r[1]};
                    sh_r     <= tick ? cap_r : (sh_r >> 2);
                end
                DUAL_EDGE_FOUR_TO_ONE_MODE:
                begin
                    q_rise_r <= {sh_r[CELL_B_LSB], sh_r[0]};
                    q_fall_r <= {sh_r[CELL_B_LSB+1], sh_r[1]};
                    sh_r     <= tick ? cap_r
                                     : {2'h0, sh_r[7:6], 2'h0, sh_r[3:2]};
                end
                default:
                begin
                    q_rise_r <= {1'b0, sh_r[0]};
                    q_fall_r <= {1'b0, sh_r[0]};
                    sh_r     <= tick ? {1'b0, cap_r[BITS_SEVEN-1:0]} : (sh_r >> 1);
                end
            endcase
        end
    end
    assign q_rise_o = q_rise_r;
    assign q_fall_o = q_fall_r;

endmodule // io_gearbox_serdes

`default_nettype wire

// *** rtl/gearbox_pkg.sv ***
// Shared constants and mode encoding for the I/O gearbox
package gearbox_pkg;

    typedef enum logic [1:0] {
        SEVEN_TO_ONE_MODE,
        DUAL_EDGE_EIGHT_TO_ONE_MODE,
        DUAL_EDGE_FOUR_TO_ONE_MODE
    } ratio_mode_e;

    localparam int unsigned WORD_W        = 8;
    localparam int unsigned BITS_SEVEN    = 7;
    localparam int unsigned BITS_EIGHT    = 8;
    localparam int unsigned BITS_FOUR     = 4;
    localparam int unsigned TICKS_SEVEN   = 7;
    localparam int unsigned TICKS_EIGHT   = 4;
    localparam int unsigned TICKS_FOUR    = 2;
    localparam int unsigned PHASE_W       = 3;
    localparam int unsigned HIST_W        = 17;
    localparam int unsigned CELL_B_LSB    = 4;
    localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;

endpackage

// *** sim/io_gearbox_serdes_monitor.sv ***
// Port checker for the gearbox
`timescale 1ns/1ps
`default_nettype none
module io_gearbox_serdes_monitor #(
    parameter int unsigned DATA_W = 8
) (
    // Clock, reset, mode
    input wire logic              clock_i,
    input wire logic              rst_i,
    input wire logic [1:0]        ratio_mode_i,
    // Outputs watched
    input wire logic              sys_tick_o,
    input wire logic [1:0]        q_rise_o,
    input wire logic [1:0]        q_fall_o,
    input wire logic              tx_ready_o,
    input wire logic              rx_valid_o,
    input wire logic              rx_ready_i,
    input wire logic [DATA_W-1:0] rx_data_o,
    input wire logic              rx_drop_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence gap7_s; (!sys_tick_o)[*6] ##1 sys_tick_o; endsequence
    sequence gap4_s; (!sys_tick_o)[*3] ##1 sys_tick_o; endsequence
    sequence gap2_s; !sys_tick_o ##1 sys_tick_o; endsequence
    a_tick_seven: assert property (sys_tick_o && ratio_mode_i == 2'h0 |=> gap7_s)
        else $error("seven mode tick spacing wrong");
    a_tick_eight: assert property (sys_tick_o && ratio_mode_i == 2'h1 |=> gap4_s)
        else $error("eight mode tick spacing wrong");
    a_tick_four: assert property (sys_tick_o && ratio_mode_i == 2'h2 |=> gap2_s)
        else $error("four mode tick spacing wrong");
    a_reset_clears: assert property (disable iff (1'b0) rst_i ##1 rst_i |-> q_rise_o == 2'h0
        && q_fall_o == 2'h0 && !rx_valid_o && !rx_drop_o && tx_ready_o && sys_tick_o)
        else $error("outputs not cleared in reset");
    a_cell_b_idle: assert property (ratio_mode_i != 2'h2 |-> q_rise_o[1] == 1'b0 && q_fall_o[1] == 1'b0)
        else $error("second cell active outside four mode");
    a_seven_single_rate: assert property (ratio_mode_i == 2'h0 |-> q_rise_o[0] == q_fall_o[0])
        else $error("seven mode halves differ");
    a_rx_word_holds: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("receive word changed while stalled");
    a_drop_when_full: assert property (rx_drop_o |-> rx_valid_o)
        else $error("drop without held word");
    a_rx_latency: assert property ($rose(rx_valid_o) |-> $past(sys_tick_o, 3))
        else $error("receive word not three cycles after tick");
endmodule // io_gearbox_serdes_monitor
`default_nettype wire

// *** sim/core_sink.sv ***
// Core-side receive sink that stalls at random
`timescale 1ns/1ps
`default_nettype none
module core_sink (
    input  wire logic clock_i,
    input  wire logic hold_i,
    output var  logic rx_ready_o = 1'b0
);
    always @(posedge clock_i)
        rx_ready_o <= !hold_i && ($urandom % 4 != 0);
endmodule // core_sink
`default_nettype wire

// *** sim/io_gearbox_serdes_test.sv ***
// Self-checking bench for the gearbox
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module io_gearbox_serdes_test;
    import gearbox_pkg::*;
    logic clock_i = 0, rst_i = 1, align_load_i = 0, align_select_i = 0, pin_rise_i = 0, pin_fall_i = 0;
    logic tx_valid_i = 0, hold = 0, sys_tick_o, tx_ready_o, rx_valid_o, rx_ready_i, rx_drop_o, rx_chk = 0;
    logic [1:0] ratio_mode_i = 0, q_rise_o, q_fall_o;
    logic [7:0] tx_data_i = 0, rx_data_o, got, msk, rx_exp, w0, w1;
    logic [7:0] exp_q[$];
    int bad_count = 0, samples_checked = 0, k, n, m, refused, drops = 0;
    always #5 clock_i = ~clock_i;
    io_gearbox_serdes io_gearbox_serdes_inst (.clock_i(clock_i), .rst_i(rst_i), .ratio_mode_i(ratio_mode_i),
        .align_load_i(align_load_i), .align_select_i(align_select_i), .pin_rise_i(pin_rise_i),
        .pin_fall_i(pin_fall_i), .q_rise_o(q_rise_o), .q_fall_o(q_fall_o), .sys_tick_o(sys_tick_o),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .rx_drop_o(rx_drop_o));
    core_sink core_sink_inst (.clock_i(clock_i), .hold_i(hold), .rx_ready_o(rx_ready_i));
    task automatic start(input logic [1:0] md);
        rst_i <= 1'b1;
        ratio_mode_i <= md;
        exp_q.delete();
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
    endtask
    task automatic send(input logic [7:0] d);
        tx_valid_i <= 1'b1;
        tx_data_i <= d;
        do
        begin
            @(negedge clock_i);
            refused += (tx_ready_o !== 1'b1);
        end
        while (tx_ready_o !== 1'b1);
        @(posedge clock_i);
        exp_q.push_back(d);
    endtask
    task automatic wrap_up;
        $display("checked=%0d errors=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial forever
    begin
        @(negedge clock_i);
        if (rx_chk && rx_valid_o && rx_ready_i)
            `CHK(rx_data_o, rx_exp)
        drops += (rx_drop_o === 1'b1);
        if (q_rise_o[0] === 1'b1 && exp_q.size() == 0)
            `CHK(q_rise_o[0], 1'b0)
        else if (q_rise_o[0] === 1'b1)
        begin
            n = ratio_mode_i == 0 ? 7 : ratio_mode_i == 1 ? 4 : 2;
            got = 8'h00;
            for (k = 0; k < n; k++)
            begin
                if (k > 0)
                    @(negedge clock_i);
                if (ratio_mode_i == 0)
                    got[k] = q_rise_o[0];
                else
                    {got[2*k+1], got[2*k]} = {q_fall_o[0], q_rise_o[0]};
                if (ratio_mode_i == 2)
                    {got[2*k+5], got[2*k+4]} = {q_fall_o[1], q_rise_o[1]};
            end
            `CHK(got, exp_q.pop_front())
        end
    end
    initial
    begin
        #50us;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(43));
        for (m = 0; m < 3; m++)
        begin
            msk = m == 0 ? 8'h7F : 8'hFF;
            start(m[1:0]);
            send(8'h01);
            start(m[1:0]);
            repeat (3)
            begin
                send((8'($urandom) & msk) | 8'h01);
                tx_valid_i <= 1'b0;
                repeat (20) @(posedge clock_i);
            end
            refused = 0;
            repeat (5) send((8'($urandom) & msk) | 8'h01);
            tx_valid_i <= 1'b0;
            `CHK(refused > 0, 1'b1)
            pin_rise_i <= 1'b1;
            pin_fall_i <= 1'b1;
            repeat (30) @(posedge clock_i);
            rx_exp = m == 0 ? 8'h7F : m == 1 ? 8'hFF : 8'h0F;
            rx_chk = 1'b1;
            hold <= 1'b1;
            repeat (40) @(posedge clock_i);
            hold <= 1'b0;
            repeat (40) @(posedge clock_i);
            rx_chk = 1'b0;
        end
        `CHK(drops > 0, 1'b1)
        start(2'h1);
        pin_fall_i <= 1'b0;
        align_load_i <= 1'b1;
        repeat (30) @(posedge clock_i);
        @(negedge clock_i);
        w0 = rx_data_o;
        `CHK(w0, 8'h55)
        @(posedge clock_i);
        align_select_i <= 1'b1;
        repeat (30) @(posedge clock_i);
        @(negedge clock_i);
        w1 = rx_data_o;
        `CHK(w1, ~w0)
        @(posedge clock_i);
        align_load_i <= 1'b0;
        align_select_i <= 1'b0;
        repeat (30) @(posedge clock_i);
        @(negedge clock_i);
        `CHK(rx_data_o, w1)
        wrap_up();
    end
endmodule // io_gearbox_serdes_test
bind io_gearbox_serdes io_gearbox_serdes_monitor #(.DATA_W(DATA_W)) mon_inst (.clock_i(clock_i), .rst_i(rst_i),
    .ratio_mode_i(ratio_mode_i), .sys_tick_o(sys_tick_o), .q_rise_o(q_rise_o), .q_fall_o(q_fall_o),
    .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
    .rx_drop_o(rx_drop_o));
`default_nettype wire
